// ### hdl/plr_port_latch.sv
`timescale 1ns/1ps
`include "plr_defs.svh"

// Functional notes
// RL1: Alternate function passes only when latch one
// RL2: Compare outputs P1.0-3 ignore latch
// RL3: Reset loads all latch bits one
// RL4: Latch write lands at state six phase two
// RL5: Output buffer samples latch in phase one
// RL6: New value reaches pin at state one phase one; here pinOut changes at state two phase one
// RL7: Pin read sampled during state five
// RL8: Edge when sample differs from previous cycle
// RL9: External levels last one machine cycle
// RL10: Read-modify-write reads latch, writes latch
// RL11: Other reads take pin values
// RL12: Listed logic, bit, count ops are RMW
// RL13: Bit writes rewrite whole latch byte
// RL14: P1.0-3 irq and compare, P1.4 irq
// RL15: P1.5, P1.7 timer two, P1.6 tick
// RL16: P3.0 serial data, P3.1 transmit/clock
// RL17: P3.2-7 irqs, timer counts, memory strobes
// RL18: Strong pullup two periods on zero-to-one
// RL19: Bus mode frees latch, port zero gets ones
// RL20: Pin level is latch AND alternate output
// RL21: Pin read synchronised, latch read exact
module plr_port_latch #(
  parameter int PORT_W = `PLR_PORT_W,
  parameter bit BUS_PORT_ZERO = 1'b0
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  wrReq,
  input  wire plr_pkg::plr_op_e      wrOp,
  input  wire logic [PORT_W-1:0]     wrData,
  input  wire logic [2:0]            wrBit,
  input  wire logic                  carryIn,
  input  wire logic                  lastCycle,
  input  wire logic                  busMode,
  input  wire logic [PORT_W-1:0]     busOut,
  input  wire logic [PORT_W-1:0]     altOut,
  input  wire logic [PORT_W-1:0]     compareMode,
  input  wire logic [PORT_W-1:0]     compareOut,
  input  wire logic [PORT_W-1:0]     pinIn,
  input  wire logic                  latePhase,
  output logic [PORT_W-1:0]          pinOut,
  output logic [PORT_W-1:0]          pinOe_n,
  output logic [PORT_W-1:0]          boostOn,
  output logic [PORT_W-1:0]          pinRead,
  output logic [PORT_W-1:0]          latchRead,
  output logic [PORT_W-1:0]          altIn,
  output logic [PORT_W-1:0]          edgeSeen,
  output logic [`PLR_STATE_W-1:0]    stateNum,
  output logic                       phaseTwo
);

  // --------------------------------------------------------------------------
  // Machine cycle sequencer
  // --------------------------------------------------------------------------
  plr_pkg::plr_phase_e       phase_reg;
  logic [`PLR_STATE_W-1:0]   state_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_reg <= plr_pkg::PLR_PH_ONE;
      state_reg <= `PLR_STATE_ONE;
    end else begin
      case (phase_reg)
        plr_pkg::PLR_PH_ONE: begin
          phase_reg <= plr_pkg::PLR_PH_TWO;
        end
        default: begin
          phase_reg <= plr_pkg::PLR_PH_ONE;
          if (state_reg == `PLR_STATE_SIX) begin
            state_reg <= `PLR_STATE_ONE;
          end else begin
            state_reg <= state_reg + 3'h1;
          end
        end
      endcase
    end
  end

  logic isPh1;
  logic isS6P2;
  logic isS5;
  assign isPh1  = (phase_reg == plr_pkg::PLR_PH_ONE);
  assign isS6P2 = (state_reg == `PLR_STATE_SIX) && !isPh1;
  assign isS5   = (state_reg == `PLR_STATE_FIVE);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stateNum <= `PLR_STATE_ONE;
      phaseTwo <= 1'b0;
    end else begin
      stateNum <= state_reg;
      phaseTwo <= isPh1;
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchroniser: three stages, change accepted when 2nd and 3rd agree
  // --------------------------------------------------------------------------
  logic [PORT_W-1:0] sync1_reg;
  logic [PORT_W-1:0] sync2_reg;
  logic [PORT_W-1:0] sync3_reg;
  logic [PORT_W-1:0] pinLvl_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_reg  <= `PLR_SAMPLE_RST;
      sync2_reg  <= `PLR_SAMPLE_RST;
      sync3_reg  <= `PLR_SAMPLE_RST;
      pinLvl_reg <= `PLR_SAMPLE_RST;
    end else begin
      sync1_reg <= pinIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < PORT_W; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          pinLvl_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Latch with read-modify-write datapath
  // --------------------------------------------------------------------------
  logic [PORT_W-1:0] latch_reg;
  logic [PORT_W-1:0] latch_next;
  logic [PORT_W-1:0] bitMask;

  assign bitMask = PORT_W'(1) << wrBit;

  always_comb begin
    // Byte and bit ops other than PLR_OP_MOV start from the latch, never the pins
    latch_next = latch_reg; // RL10
    case (wrOp)
      plr_pkg::PLR_OP_MOV:  latch_next = wrData; // RL11
      plr_pkg::PLR_OP_ANL:  latch_next = latch_reg & wrData; // RL12
      plr_pkg::PLR_OP_ORL:  latch_next = latch_reg | wrData; // RL12
      plr_pkg::PLR_OP_XRL:  latch_next = latch_reg ^ wrData; // RL12
      plr_pkg::PLR_OP_INC:  latch_next = latch_reg + PORT_W'(1); // RL12
      plr_pkg::PLR_OP_DEC,
      plr_pkg::PLR_OP_DJNZ: latch_next = latch_reg - PORT_W'(1); // RL12
      plr_pkg::PLR_OP_JBC,
      plr_pkg::PLR_OP_CLR:  latch_next = latch_reg & ~bitMask; // RL13
      plr_pkg::PLR_OP_CPL:  latch_next = latch_reg ^ bitMask; // RL12
      plr_pkg::PLR_OP_SETB: latch_next = latch_reg | bitMask; // RL13
      plr_pkg::PLR_OP_MOVC: begin
        latch_next = carryIn ? (latch_reg | bitMask)
                             : (latch_reg & ~bitMask); // RL13
      end
      default: latch_next = latch_reg;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latch_reg <= `PLR_LATCH_RST; // RL3
    end else if (busMode && BUS_PORT_ZERO) begin
      latch_reg <= `PLR_LATCH_RST; // RL19
    end else if (wrReq && lastCycle && isS6P2) begin
      latch_reg <= latch_next; // RL4
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latchRead <= `PLR_LATCH_RST;
    end else begin
      latchRead <= latch_reg; // RL21
    end
  end

  // --------------------------------------------------------------------------
  // Output buffer: follows latch in phase 1 only
  // --------------------------------------------------------------------------
  logic [PORT_W-1:0] buf_reg;
  logic [PORT_W-1:0] drive;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      buf_reg <= `PLR_LATCH_RST;
    end else if (isPh1) begin
      // Taken at the end of phase 1 only; held through phase 2
      buf_reg <= latch_reg; // RL5 RL6
    end
  end

  genvar g;
  generate
    for (g = 0; g < PORT_W; g++) begin : gBit
      always_comb begin
        if (busMode) begin
          drive[g] = busOut[g]; // RL19
        end else if (compareMode[g] && g <= `PLR_P1_CC_HI) begin
          drive[g] = compareOut[g]; // RL2 RL14
        end else begin
          drive[g] = buf_reg[g] & altOut[g]; // RL1 RL20
        end
      end
    end
  endgenerate

  logic [PORT_W-1:0] prevDrive_reg;
  logic [PORT_W-1:0] boostCnt_reg [PORT_W];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prevDrive_reg <= `PLR_LATCH_RST;
      pinOut        <= `PLR_LATCH_RST;
      pinOe_n       <= `PLR_LATCH_RST;
      boostOn       <= '0;
    end else begin
      prevDrive_reg <= drive;
      pinOut        <= drive;
      // Quasi-bidirectional: only a zero is actively driven
      pinOe_n       <= drive; // RL1
      for (int i = 0; i < PORT_W; i++) begin
        boostOn[i] <= (drive[i] && !prevDrive_reg[i]) ||
                      (boostOn[i] && boostCnt_reg[i] == PORT_W'(0)); // RL18
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < PORT_W; i++) begin
      if (rst) begin
        boostCnt_reg[i] <= '0;
      end else if (drive[i] && !prevDrive_reg[i]) begin
        boostCnt_reg[i] <= '0;
      end else if (boostOn[i]) begin
        boostCnt_reg[i] <= PORT_W'(`PLR_BOOST_PHASES - 1); // RL18
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin sampling in state 5 and per-cycle edge detection
  // --------------------------------------------------------------------------
  logic [PORT_W-1:0] sample_reg;
  logic              takeSample;

  assign takeSample = isS5 && (latePhase ? !isPh1 : isPh1); // RL7

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sample_reg <= `PLR_SAMPLE_RST;
      pinRead    <= `PLR_SAMPLE_RST;
      altIn      <= `PLR_SAMPLE_RST;
      edgeSeen   <= '0;
    end else if (takeSample) begin
      sample_reg <= pinLvl_reg; // RL8 RL9
      pinRead    <= pinLvl_reg; // RL11 RL21
      // Alternate inputs see the pin only while the latch holds one
      altIn      <= pinLvl_reg & latch_reg; // RL1 RL14 RL15 RL16 RL17
      edgeSeen   <= pinLvl_reg ^ sample_reg; // RL8
    end else begin
      edgeSeen   <= '0;
    end
  end

endmodule

// ### hdl/plr_defs.svh
`ifndef PLR_DEFS_SVH
`define PLR_DEFS_SVH

// ----------------------------------------------------------------------------
// Port widths and reset values
// ----------------------------------------------------------------------------
`define PLR_PORT_W        8
`define PLR_LATCH_RST     8'hFF
`define PLR_SAMPLE_RST    8'hFF

// ----------------------------------------------------------------------------
// Machine cycle timing: 6 states of 2 phases each
// ----------------------------------------------------------------------------
`define PLR_STATES        6
`define PLR_STATE_W       3
`define PLR_STATE_ONE     3'h0
`define PLR_STATE_FIVE    3'h4
`define PLR_STATE_SIX     3'h5
`define PLR_BOOST_PHASES  2

// ----------------------------------------------------------------------------
// Port 1 and port 3 bit positions
// ----------------------------------------------------------------------------
`define PLR_P1_CC_LO      0
`define PLR_P1_CC_HI      3
`define PLR_P1_IRQ2       4
`define PLR_P1_T2RELOAD   5
`define PLR_P1_TICK       6
`define PLR_P1_T2IN       7
`define PLR_P3_RXD        0
`define PLR_P3_TXD        1
`define PLR_P3_IRQ0       2
`define PLR_P3_IRQ1       3
`define PLR_P3_T0IN       4
`define PLR_P3_T1IN       5
`define PLR_P3_WRS        6
`define PLR_P3_RDS        7

`endif

// ### hdl/plr_pkg.sv
package plr_pkg;

  typedef logic [7:0] plr_byte_t;

  // Byte or bit operation applied to the latch by a port write
  typedef enum logic [3:0] {
    PLR_OP_MOV,
    PLR_OP_ANL,
    PLR_OP_ORL,
    PLR_OP_XRL,
    PLR_OP_JBC,
    PLR_OP_CPL,
    PLR_OP_INC,
    PLR_OP_DEC,
    PLR_OP_DJNZ,
    PLR_OP_MOVC,
    PLR_OP_CLR,
    PLR_OP_SETB
  } plr_op_e;

  typedef enum logic [1:0] {
    PLR_PH_ONE,
    PLR_PH_TWO
  } plr_phase_e;

endpackage

// ### sim/plr_port_latch_props.sv
`timescale 1ns/1ps
module plr_port_latch_props #(
  parameter int PORT_W = 8
) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              wrReq,
  input wire logic              lastCycle,
  input wire logic              busMode,
  input wire logic [PORT_W-1:0] altOut,
  input wire logic [PORT_W-1:0] compareMode,
  input wire logic [PORT_W-1:0] pinOut,
  input wire logic [PORT_W-1:0] boostOn,
  input wire logic [PORT_W-1:0] pinRead,
  input wire logic [PORT_W-1:0] latchRead,
  input wire logic [PORT_W-1:0] edgeSeen,
  input wire logic              phaseTwo
);
  // ----
  // History
  // ----
  logic      [PORT_W-1:0] boostPrev;
  int unsigned            edgeGap;
  int unsigned            readGap;
  wire logic [PORT_W-1:0] boostNew = boostOn & ~boostPrev;

  always_ff @(posedge sys_clk) begin
    boostPrev <= rst ? '0 : boostOn;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      edgeGap <= 100;
      readGap <= 100;
    end else begin
      edgeGap <= (edgeSeen != '0) ? 0 : edgeGap + 1;
      readGap <= !$stable(pinRead) ? 0 : readGap + 1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  reset_values_a: assert property (@(posedge sys_clk) disable iff (1'b0)
    rst |=> latchRead == 8'hFF && pinOut == 8'hFF && boostOn == 8'h00)
    else $error("Port state wrong after reset");
  latch_write_a: assert property (
    !$stable(latchRead) && !$past(rst) |->
    $past(wrReq, 2) && $past(lastCycle, 2))
    else $error("Latch changed without a final-cycle write");
  pin_follow_a: assert property (
    !$stable(latchRead) && !busMode && &altOut && compareMode == 8'h00
    |=> pinOut == $past(latchRead))
    else $error("Pin did not follow latch one clock later");
  latch_gate_a: assert property (
    !busMode && !$past(busMode) && !$past(busMode, 2) &&
    compareMode == 8'h00 && $past(compareMode) == 8'h00 &&
    $past(compareMode, 2) == 8'h00 |-> (pinOut & ~$past(latchRead)) == 8'h00)
    else $error("Pin high while latch bit is zero");
  boost_two_a: assert property (
    boostNew != 8'h00 |=> (boostOn & $past(boostNew)) == $past(boostNew)
    ##1 (boostOn & $past(boostNew, 2)) == 8'h00)
    else $error("Strong pullup not exactly two clocks");
  phase_alt_a: assert property (
    !$past(rst) |-> phaseTwo != $past(phaseTwo))
    else $error("Phase did not alternate");
  edge_pulse_a: assert property (
    edgeSeen != 8'h00 |=> edgeSeen == 8'h00)
    else $error("Edge pulse longer than one clock");
  edge_space_a: assert property (
    edgeSeen != 8'h00 |-> edgeGap >= 11)
    else $error("Edges closer than one machine cycle");
  read_space_a: assert property (
    !$stable(pinRead) && !$past(rst) |-> readGap >= 11)
    else $error("Pin sample more than once per machine cycle");
endmodule

bind plr_port_latch plr_port_latch_props #(.PORT_W(PORT_W)) u_props (
  .sys_clk(sys_clk), .rst(rst), .wrReq(wrReq), .lastCycle(lastCycle),
  .busMode(busMode), .altOut(altOut), .compareMode(compareMode),
  .pinOut(pinOut), .boostOn(boostOn), .pinRead(pinRead),
  .latchRead(latchRead), .edgeSeen(edgeSeen), .phaseTwo(phaseTwo));

// ### sim/plr_ext_pins.sv
`timescale 1ns/1ps
module plr_ext_pins (
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe_n,
  input  wire logic [7:0] extLow,
  output logic      [7:0] pinIn
);
  // Released pins sit at the pull-up; any low driver wins
  assign pinIn = (pinOe_n | pinOut) & ~extLow;
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ----
  // Signals
  // ----
  logic             sys_clk = 1'b0;
  logic             rst = 1'b1;
  logic             wrReq = 1'b0;
  logic             lastCycle = 1'b0;
  logic             carryIn = 1'b0;
  logic             busMode = 1'b0;
  logic             latePhase = 1'b0;
  logic             phaseTwo;
  logic [2:0]       wrBit = 3'h0;
  logic [2:0]       stateNum;
  plr_pkg::plr_op_e wrOp = plr_pkg::PLR_OP_MOV;
  logic [7:0]       wrData = 8'h00;
  logic [7:0]       busOut = 8'h00;
  logic [7:0]       altOut = 8'hFF;
  logic [7:0]       compareMode = 8'h00;
  logic [7:0]       compareOut = 8'h00;
  logic [7:0]       extLow = 8'h00;
  logic [7:0]       pinIn, pinOut, pinOe_n, boostOn;
  logic [7:0]       pinRead, latchRead, altIn, edgeSeen;
  int               bad_count = 0;
  int               compares = 0;

  plr_port_latch u_dut (
    .sys_clk(sys_clk), .rst(rst), .wrReq(wrReq), .wrOp(wrOp),
    .wrData(wrData), .wrBit(wrBit), .carryIn(carryIn),
    .lastCycle(lastCycle), .busMode(busMode), .busOut(busOut),
    .altOut(altOut), .compareMode(compareMode), .compareOut(compareOut),
    .pinIn(pinIn), .latePhase(latePhase), .pinOut(pinOut),
    .pinOe_n(pinOe_n), .boostOn(boostOn), .pinRead(pinRead),
    .latchRead(latchRead), .altIn(altIn), .edgeSeen(edgeSeen),
    .stateNum(stateNum), .phaseTwo(phaseTwo));
  plr_ext_pins u_pins (.pinOut(pinOut), .pinOe_n(pinOe_n),
    .extLow(extLow), .pinIn(pinIn));

  always #10 sys_clk = ~sys_clk;

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // One write spans a whole machine cycle, so it holds one STATE_SIX_PHASE_TWO edge
  task automatic wr(input plr_pkg::plr_op_e op, input logic [7:0] d,
                    input logic [2:0] b, input logic c, input logic [7:0] e);
    @(negedge sys_clk);
    wrOp = op;
    wrData = d;
    wrBit = b;
    carryIn = c;
    wrReq = 1'b1;
    lastCycle = 1'b1;
    cyc(12);
    wrReq = 1'b0;
    lastCycle = 1'b0;
    cyc(3);
    chk(latchRead, e);
  endtask
  task automatic t_rmw();
    logic [7:0] dat [12] = '{8'h5A, 8'h0F, 8'hC0, 8'hFF, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [2:0] bt [12] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h0,
                            3'h0, 3'h0, 3'h0, 3'h7, 3'h0, 3'h4};
    logic [7:0] ex [12] = '{8'h5A, 8'h0A, 8'hCA, 8'h35, 8'h31, 8'h30,
                            8'h31, 8'h30, 8'h2F, 8'hAF, 8'hAE, 8'hBE};
    extLow = 8'hFF;
    for (int i = 0; i < 12; i++) begin
      wr(plr_pkg::plr_op_e'(i), dat[i], bt[i], i == 9, ex[i]);
    end
    chk(pinRead, 8'h00);
    extLow = 8'h00;
  endtask
  task automatic t_pins();
    wr(plr_pkg::PLR_OP_MOV, 8'hFF, 3'h0, 1'b0, 8'hFF);
    extLow = 8'h0F;
    cyc(30);
    chk(pinRead, 8'hF0);
    chk(latchRead, 8'hFF);
    chk(altIn, 8'hF0);
    extLow = 8'h00;
    cyc(30);
  endtask
  task automatic t_edge();
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 72; i++) begin
      if (i == 0) extLow = 8'h08;
      if (i == 24) extLow = 8'h00;
      cyc(1);
      if (edgeSeen[3] === 1'b1) n++;
    end
    chk(n, 8'h02);
  endtask
  task automatic t_boost();
    logic [7:0] n;
    n = 8'h00;
    wr(plr_pkg::PLR_OP_MOV, 8'h00, 3'h0, 1'b0, 8'h00);
    fork
      wr(plr_pkg::PLR_OP_MOV, 8'hFF, 3'h0, 1'b0, 8'hFF);
      repeat (24) begin
        cyc(1);
        if (boostOn[7] === 1'b1) n++;
      end
    join
    chk(n, 8'h02);
  endtask
  task automatic t_alt();
    wr(plr_pkg::PLR_OP_MOV, 8'hFE, 3'h0, 1'b0, 8'hFE);
    altOut = 8'hFD;
    cyc(4);
    chk(pinOut & 8'h03, 8'h00);
    chk(pinOe_n & 8'h03, 8'h00);
    compareMode = 8'h01;
    compareOut = 8'h01;
    cyc(4);
    chk(pinOut & 8'h03, 8'h01);
    altOut = 8'hFF;
    compareMode = 8'h00;
    cyc(4);
    busMode = 1'b1;
    busOut = 8'h3C;
    cyc(4);
    chk(pinOut, 8'h3C);
    chk(latchRead, 8'hFE);
    busMode = 1'b0;
    cyc(4);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    cyc(16);
    rst = 1'b0;
    chk(latchRead, 8'hFF);
    chk(pinOut, 8'hFF);
    chk(edgeSeen, 8'h00);
    t_rmw();
    t_pins();
    t_edge();
    t_boost();
    t_alt();
    tally_and_finish();
  end
endmodule
